//--- verilog/rsi_pkg.sv
`default_nettype none
package rsi_pkg;
   localparam logic [15:0] RSI_PC_MCU = 16'hFFFE;
   localparam logic [15:0] RSI_PC_PROM = 16'h1FFE;
   localparam logic [15:0] RSI_SP_RST = 16'h00FF;
   localparam logic [15:0] RSI_VEC_LO = 16'hFFFE;
   localparam logic [15:0] RSI_VEC_HI = 16'hFFFF;
   localparam logic [7:0] RSI_ZERO8 = 8'h00;
   localparam int RSI_CLK_MHZ = 50;
   localparam int RSI_WARMUP_US = 100;
   localparam int RSI_WARMUP_CYC = RSI_WARMUP_US * RSI_CLK_MHZ;
   localparam logic [7:0] RSI_OFS_CTRL = 8'h00;
   localparam logic [7:0] RSI_OFS_IRQ_EN = 8'h04;
   localparam logic [7:0] RSI_OFS_IRQ_PEND = 8'h08;
   localparam logic [7:0] RSI_OFS_PORT_DIR = 8'h0C;
   localparam logic [7:0] RSI_OFS_PORT_OUT = 8'h10;
   localparam logic [7:0] RSI_OFS_PORT_IN = 8'h14;
   localparam logic [7:0] RSI_OFS_STATUS = 8'h18;
   localparam logic [7:0] RSI_OFS_PRESC = 8'h1C;
   localparam int RSI_CTRL_LVD = 0;
   localparam int RSI_CTRL_LFOSC = 1;
   localparam int RSI_CTRL_GIE = 2;
   localparam int RSI_CTRL_BANK = 3;
   typedef enum logic [1:0] {
      RSI_ST_RESET,
      RSI_ST_WARMUP,
      RSI_ST_RUN
   } rsi_state_e;
endpackage : rsi_pkg
`default_nettype wire

//--- verilog/rsi_reset_init.sv
//
// Notes on behaviour
// - Program counter and stack pointer held at presets.
// - Bank select zero until execution.
// - Global interrupt enable cleared by reset.
// - Source enables and pending latches cleared.
// - RAM, working registers, flags left untouched.
// - High-frequency oscillator always enabled.
// - Low-frequency oscillator off until execution.
// - Prescaler held at zero until execution.
// - Warm-up counter sequencing; watchdog after warm-up.
// - Only power-on or pin reset clears detector.
// - Warm-up counts clocks, then vector fetch.
// - Reset during warm-up restarts the counter.
`timescale 1ns/1ns
`default_nettype none
module rsi_reset_init
   import rsi_pkg::*;
#(
   parameter int WARMUP_CYCLES = RSI_WARMUP_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic por_rst,
   input wire logic ext_rst,
   input wire logic int_rst,
   input wire logic serial_prom_mode,
   input wire logic [7:0] irq_req,
   input wire logic [7:0] port_in,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic [15:0] program_counter,
   output logic [15:0] stack_pointer,
   output logic [15:0] vector_addr,
   output logic cpu_start,
   output logic cpu_run,
   output logic bank_select,
   output logic global_irq_enable,
   output logic [7:0] source_irq_enable,
   output logic [7:0] irq_pending_latch,
   output logic high_freq_osc_en,
   output logic low_freq_osc_en,
   output logic [7:0] prescaler,
   output logic watchdog_enable,
   output logic lvd_enable,
   output logic [7:0] port_out,
   output logic [7:0] port_oe
);

   localparam int CW = $clog2(WARMUP_CYCLES);
   localparam logic [CW-1:0] WU_LAST = CW'(WARMUP_CYCLES - 1);

   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   ////////////////////////////////////////////////////////////////////
   rsi_state_e state;
   rsi_state_e next_state;
   logic [CW-1:0] wu_cnt;
   wire in_reset = por_rst | ext_rst | int_rst;
   wire wu_done = (wu_cnt == WU_LAST);
   wire next_run = (next_state == RSI_ST_RUN);
   wire sw_ok = (state == RSI_ST_RUN) & ~in_reset;

   // Every reset source pulls the sequence back to the start.
   always_comb begin
      next_state = state;
      case (state)
         RSI_ST_RESET: begin
            next_state = RSI_ST_WARMUP;
         end
         RSI_ST_WARMUP: begin
            if (wu_done) begin
               next_state = RSI_ST_RUN;
            end
         end
         RSI_ST_RUN: begin
            next_state = RSI_ST_RUN;
         end
         default: begin
            next_state = RSI_ST_RESET;
         end
      endcase
      if (in_reset) begin
         next_state = RSI_ST_RESET;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= RSI_ST_RESET;
      end else begin
         state <= next_state;
      end
   end

   // Counter is cleared outside warm-up and counts clock cycles.
   always_ff @(posedge clk) begin
      if (!nrst || next_state != RSI_ST_WARMUP) begin
         wu_cnt <= '0;
      end else if (state == RSI_ST_WARMUP) begin
         wu_cnt <= wu_cnt + CW'(1);
      end
   end

   // The start pulse marks the first cycle of execution, rising on the same edge that ends warm-up.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cpu_start <= 1'b0;
      end else begin
         cpu_start <= (state == RSI_ST_WARMUP) & wu_done & ~in_reset;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Presets are re-driven every cycle so the core can load them at any
   // time; the core owns RAM, working registers and flags.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         program_counter <= serial_prom_mode ? RSI_PC_PROM : RSI_PC_MCU;
         stack_pointer <= RSI_SP_RST;
         vector_addr <= RSI_VEC_LO;
         high_freq_osc_en <= 1'b1;
      end else begin
         program_counter <= serial_prom_mode ? RSI_PC_PROM : RSI_PC_MCU;
         stack_pointer <= RSI_SP_RST;
         vector_addr <= RSI_VEC_LO;
         high_freq_osc_en <= 1'b1;
      end
   end

   assign cpu_run = (state == RSI_ST_RUN);

   ////////////////////////////////////////////////////////////////////
   wire wr_ctrl = wr & sw_ok & hit(addr, RSI_OFS_CTRL);
   wire wr_ien = wr & sw_ok & hit(addr, RSI_OFS_IRQ_EN);
   wire wr_pend = wr & sw_ok & hit(addr, RSI_OFS_IRQ_PEND);
   wire wr_dir = wr & sw_ok & hit(addr, RSI_OFS_PORT_DIR);
   wire wr_out = wr & sw_ok & hit(addr, RSI_OFS_PORT_OUT);
   wire [7:0] pend_clr = wr_pend ? wdata : RSI_ZERO8;
   // A request in the clearing cycle survives the clear.
   wire [7:0] next_pend = (irq_pending_latch & ~pend_clr) | irq_req;

   // Everything here drops with the state, so values read zero the same
   // cycle the sequence leaves execution.
   always_ff @(posedge clk) begin
      if (!nrst || !next_run) begin
         bank_select <= 1'b0;
         global_irq_enable <= 1'b0;
         source_irq_enable <= RSI_ZERO8;
         irq_pending_latch <= RSI_ZERO8;
         low_freq_osc_en <= 1'b0;
         prescaler <= RSI_ZERO8;
         port_oe <= RSI_ZERO8;
         port_out <= RSI_ZERO8;
      end else begin
         if (wr_ctrl) begin
            bank_select <= wdata[RSI_CTRL_BANK];
            global_irq_enable <= wdata[RSI_CTRL_GIE];
            low_freq_osc_en <= wdata[RSI_CTRL_LFOSC];
         end
         if (wr_ien) begin
            source_irq_enable <= wdata;
         end
         if (wr_dir) begin
            port_oe <= wdata;
         end
         if (wr_out) begin
            port_out <= wdata;
         end
         irq_pending_latch <= sw_ok ? next_pend : RSI_ZERO8;
         prescaler <= sw_ok ? prescaler + 8'h01 : RSI_ZERO8;
      end
   end

   // Watchdog rises on the edge that enters execution.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         watchdog_enable <= 1'b0;
      end else begin
         watchdog_enable <= next_run;
      end
   end

   // Internal resets must not drop the detector, or a supply dip seen
   // by the detector would disarm the detector itself.
   always_ff @(posedge clk) begin
      if (!nrst || por_rst || ext_rst) begin
         lvd_enable <= 1'b0;
      end else if (wr_ctrl) begin
         lvd_enable <= wdata[RSI_CTRL_LVD];
      end
   end

   ////////////////////////////////////////////////////////////////////
   wire [7:0] ctrl_rd = {4'h0, bank_select, global_irq_enable,
                         low_freq_osc_en, lvd_enable};
   wire [7:0] stat_rd = {3'h0, serial_prom_mode, watchdog_enable,
                         high_freq_osc_en, state};
   wire [7:0] rd_mux =
      hit(addr, RSI_OFS_CTRL) ? ctrl_rd :
      hit(addr, RSI_OFS_IRQ_EN) ? source_irq_enable :
      hit(addr, RSI_OFS_IRQ_PEND) ? irq_pending_latch :
      hit(addr, RSI_OFS_PORT_DIR) ? port_oe :
      hit(addr, RSI_OFS_PORT_OUT) ? port_out :
      hit(addr, RSI_OFS_PORT_IN) ? port_in :
      hit(addr, RSI_OFS_STATUS) ? stat_rd :
      hit(addr, RSI_OFS_PRESC) ? prescaler : RSI_ZERO8;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata <= RSI_ZERO8;
      end else begin
         rdata <= rd ? rd_mux : RSI_ZERO8;
      end
   end

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   a_pc_preset: assert property (
      1'b1 |=> program_counter ==
         ($past(serial_prom_mode) ? RSI_PC_PROM : RSI_PC_MCU))
      else $error("program counter preset wrong");

   a_sp_preset: assert property (
      stack_pointer == RSI_SP_RST)
      else $error("stack pointer preset wrong");

   a_bank_zero: assert property (
      state != RSI_ST_RUN |-> bank_select == 1'b0)
      else $error("bank select not zero before execution");

   a_gie_clear: assert property (
      in_reset |=> !global_irq_enable && state == RSI_ST_RESET)
      else $error("global interrupt enable survived reset");

   a_irq_clear: assert property (
      state != RSI_ST_RUN |->
         source_irq_enable == RSI_ZERO8 &&
         irq_pending_latch == RSI_ZERO8)
      else $error("interrupt state not cleared");

   a_osc_state: assert property (
      state != RSI_ST_RUN |-> high_freq_osc_en && !low_freq_osc_en)
      else $error("oscillator enables wrong before execution");

   a_presc_zero: assert property (
      cpu_start && !in_reset |-> prescaler == RSI_ZERO8 ##1 prescaler == 8'h01)
      else $error("prescaler not zero at warm-up end");

   a_wdt_run: assert property (
      watchdog_enable == (state == RSI_ST_RUN))
      else $error("watchdog enable does not follow execution");

   a_warmup_len: assert property (
      cpu_start |-> state == RSI_ST_RUN && $past(wu_cnt) == WU_LAST)
      else $error("warm-up ended at wrong count");

   a_restart_cnt: assert property (
      in_reset |=> wu_cnt == '0 ##1 state != RSI_ST_RUN)
      else $error("warm-up not restarted by reset");

   a_lvd_keep: assert property (
      int_rst && !por_rst && !ext_rst && !wr_ctrl |=> $stable(lvd_enable))
      else $error("internal reset changed detector enable");

   a_lvd_clear: assert property (
      por_rst || ext_rst |=> !lvd_enable)
      else $error("detector not disabled by pin or power reset");

   a_port_hiz: assert property (
      state != RSI_ST_RUN |-> port_oe == RSI_ZERO8)
      else $error("port driven before execution");

   a_presc_hold: assert property (
      state != RSI_ST_RUN |-> prescaler == RSI_ZERO8)
      else $error("prescaler counting before execution");

   a_start_once: assert property (
      cpu_start |=> !cpu_start)
      else $error("start pulse longer than one cycle");

   c_full_boot: cover property (
      state == RSI_ST_RESET ##1 state == RSI_ST_WARMUP [*2] ##[1:8] cpu_start);
   c_warm_restart: cover property (
      state == RSI_ST_WARMUP && in_reset);
   c_int_reset_run: cover property (
      state == RSI_ST_RUN && lvd_enable && int_rst);
   c_irq_set_clr: cover property (
      wr_pend && (irq_req & wdata) != RSI_ZERO8);

endmodule : rsi_reset_init
`default_nettype wire

//--- verification/rsi_reset_init_bench.sv
`timescale 1ns/1ns
`default_nettype none
module rsi_reset_init_bench import rsi_pkg::*;;
   // A short warm-up keeps every restart cheap; all counts derive from W.
   localparam int W = 8;
   logic clk, nrst, por_rst, ext_rst, int_rst, serial_prom_mode, wr, rd;
   logic [7:0] irq_req, port_in, addr, wdata, rdata, src_en, pend;
   logic [7:0] presc, port_out, port_oe;
   logic [15:0] pc, sp, vec;
   logic cpu_start, cpu_run, bank, gie, hf, lf, wd, lvd;
   int bad_count = 0;
   int checked = 0;

   rsi_reset_init #(.WARMUP_CYCLES(W)) rsi_reset_init_i (
      .clk(clk), .nrst(nrst), .por_rst(por_rst), .ext_rst(ext_rst),
      .int_rst(int_rst), .serial_prom_mode(serial_prom_mode),
      .irq_req(irq_req), .port_in(port_in), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .program_counter(pc),
      .stack_pointer(sp), .vector_addr(vec), .cpu_start(cpu_start),
      .cpu_run(cpu_run), .bank_select(bank), .global_irq_enable(gie),
      .source_irq_enable(src_en), .irq_pending_latch(pend),
      .high_freq_osc_en(hf), .low_freq_osc_en(lf), .prescaler(presc),
      .watchdog_enable(wd), .lvd_enable(lvd), .port_out(port_out),
      .port_oe(port_oe));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (bad_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rdata", {8'h00, e}, {8'h00, rdata});
   endtask : rd_chk

   task automatic check_idle(input logic lvd_e, input logic wd_e);
      chk("pc", serial_prom_mode ? RSI_PC_PROM : RSI_PC_MCU, pc);
      chk("sp", RSI_SP_RST, sp);
      chk("bank", 16'h0000, {15'h0000, bank});
      chk("gie", 16'h0000, {15'h0000, gie});
      chk("irq", 16'h0000, {src_en, pend});
      chk("hf", 16'h0001, {15'h0000, hf});
      chk("lf", 16'h0000, {15'h0000, lf});
      chk("presc", 16'h0000, {8'h00, presc});
      chk("wd", {15'h0000, wd_e}, {15'h0000, wd});
      chk("run", {15'h0000, wd_e}, {15'h0000, cpu_run});
      chk("lvd", {15'h0000, lvd_e}, {15'h0000, lvd});
      chk("port", 16'h0000, {port_oe, port_out});
   endtask : check_idle

   // Entered at the edge that releases reset when n_exp is nonzero; the bound stops a hang.
   task automatic wait_run(input int n_exp, input logic lvd_e);
      int n;
      n = 0;
      while (cpu_start !== 1'b1 && n < 4 * W + 20) begin
         @(posedge clk);
         #1 n++;
         if (cpu_start !== 1'b1) check_idle(lvd_e, 1'b0);
      end
      check_idle(lvd_e, 1'b1);
      chk("vector", RSI_VEC_LO, vec);
      if (n_exp > 0) chk("warmup", n_exp[15:0], n[15:0]);
      @(posedge clk);
      #1 chk("start", 16'h0000, {15'h0000, cpu_start});
      chk("presc", 16'h0001, {8'h00, presc});
   endtask : wait_run

   // Source 0 is internal, 1 the pin, 2 power-on.
   task automatic hit(input int s, input logic lvd_e);
      @(posedge clk);
      {por_rst, ext_rst, int_rst} <= 3'b001 << s;
      @(posedge clk);
      @(posedge clk);
      #1 check_idle(lvd_e, 1'b0);
      @(posedge clk);
      {por_rst, ext_rst, int_rst} <= 3'b000;
   endtask : hit

   ////////////////////////////////////////////////////////////////////////
   task automatic boot_mcu();
      repeat (5) @(posedge clk);
      #1 check_idle(1'b0, 1'b0);
      @(posedge clk);
      nrst <= 1'b1;
      wait_run(W + 1, 1'b0);
   endtask : boot_mcu

   // Pending bits: a request in the clearing cycle must survive the clear.
   task automatic reg_access();
      wr_reg(RSI_OFS_CTRL, 8'h0F);
      wr_reg(RSI_OFS_IRQ_EN, 8'hFF);
      wr_reg(RSI_OFS_PORT_DIR, 8'hFF);
      wr_reg(RSI_OFS_PORT_OUT, 8'hA5);
      #1 chk("port", 16'hFFA5, {port_oe, port_out});
      @(posedge clk);
      irq_req <= 8'h81;
      port_in <= 8'h3C;
      @(posedge clk);
      irq_req <= 8'h00;
      rd_chk(RSI_OFS_CTRL, 8'h0F);
      rd_chk(RSI_OFS_IRQ_PEND, 8'h81);
      @(posedge clk);
      irq_req <= 8'h01;
      wr_reg(RSI_OFS_IRQ_PEND, 8'h81);
      irq_req <= 8'h00;
      rd_chk(RSI_OFS_IRQ_PEND, 8'h01);
      wr_reg(RSI_OFS_IRQ_PEND, 8'h01);
      rd_chk(RSI_OFS_IRQ_PEND, 8'h00);
      rd_chk(RSI_OFS_IRQ_EN, 8'hFF);
      rd_chk(RSI_OFS_PORT_DIR, 8'hFF);
      rd_chk(RSI_OFS_PORT_OUT, 8'hA5);
      rd_chk(RSI_OFS_PORT_IN, 8'h3C);
      rd_chk(RSI_OFS_STATUS, 8'h0E);
   endtask : reg_access

   task automatic warm_restart();
      hit(0, 1'b1);
      repeat (3) @(posedge clk);
      hit(0, 1'b1);
      wait_run(W + 1, 1'b1);
   endtask : warm_restart

   task automatic refused_write();
      hit(0, 1'b1);
      wr_reg(RSI_OFS_CTRL, 8'h0E);
      rd_chk(RSI_OFS_STATUS, 8'h05);
      wait_run(0, 1'b1);
      rd_chk(RSI_OFS_CTRL, 8'h01);
   endtask : refused_write

   task automatic source_kinds();
      hit(2, 1'b0);
      wait_run(W + 1, 1'b0);
      wr_reg(RSI_OFS_CTRL, 8'h01);
      rd_chk(RSI_OFS_CTRL, 8'h01);
      hit(1, 1'b0);
      wait_run(W + 1, 1'b0);
      rd_chk(8'h20, 8'h00);
   endtask : source_kinds

   task automatic boot_prom();
      @(posedge clk);
      serial_prom_mode <= 1'b1;
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check_idle(1'b0, 1'b0);
      @(posedge clk);
      nrst <= 1'b1;
      wait_run(W + 1, 1'b0);
      rd_chk(RSI_OFS_STATUS, 8'h1E);
   endtask : boot_prom

   initial begin
      nrst = 1'b0;
      {por_rst, ext_rst, int_rst} = 3'b000;
      serial_prom_mode = 1'b0;
      {wr, rd} = 2'b00;
      {irq_req, port_in, addr, wdata} = 32'h0000_005A;
      boot_mcu();
      reg_access();
      warm_restart();
      refused_write();
      source_kinds();
      boot_prom();
      give_verdict();
   end

   // The whole sequence needs under 150 cycles; 5000 is ample.
   initial begin
      #100000;
      bad_count++;
      give_verdict();
   end
endmodule : rsi_reset_init_bench
`default_nettype wire
